// File: bench/cmd_host_model.sv
// command port host model: one strobe cycle per write or read
`timescale 1ns/100ps
module cmd_host_model
(
	// clock and answer
	input  wire logic        i_clk,
	input  wire logic [15:0] i_rd_data,
	input  wire logic        i_unsup,
	// command port
	output logic             o_wr,
	output logic             o_rd,
	output logic [7:0]       o_code,
	output logic [15:0]      o_data
);
	initial
	begin
		o_wr   = 1'b0;
		o_rd   = 1'b0;
		o_code = 8'h00;
		o_data = 16'h0000;
	end

	// released code and data are inverted so a stale value never looks valid
	task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] data,
		output logic [15:0] rdata, output logic unsup);
		@(posedge i_clk);
		#1;
		o_wr   = wr;
		o_rd   = !wr;
		o_code = code;
		o_data = data;
		@(posedge i_clk);
		#1;
		o_wr   = 1'b0;
		o_rd   = 1'b0;
		o_code = ~code;
		o_data = ~data;
		rdata  = i_rd_data;
		unsup  = i_unsup;
	endtask : access
endmodule : cmd_host_model

// File: bench/test_fault_retry_ctrl.sv
// self-checking bench for the fault retry and spare pin block
`timescale 1ns/100ps
module test_fault_retry_ctrl
	import fault_retry_pkg::*;
;
	// short base unit keeps the 1 s unit at 4000 cycles
	localparam int BC  = 4;
	localparam int TMO = 20000;

	typedef struct
	{
		logic [15:0]  pins;
		logic [3:0]   unused;
		logic [3:0]   oe_b;
		fault_class_t c;
		logic [1:0]   unit;
		logic [2:0]   ex;
		logic [2:0]   r;
	} row_t;

	logic         core_clk;
	logic         rst_b;
	logic         wr;
	logic         rd;
	logic [7:0]   code;
	logic [15:0]  wdata;
	logic [15:0]  rd_data;
	logic [15:0]  rdv;
	logic         unsup;
	logic         usv;
	logic         fault;
	logic         clr;
	logic         clr_cmd;
	logic         ctrl_on;
	logic         op_on;
	logic         bias_ok;
	logic         other_sd;
	logic         out_en;
	logic         latched;
	logic [3:0]   sp_out;
	logic [3:0]   sp_oe_b;
	logic [3:0]   sp_unused;
	fault_class_t cls;
	int           err_count = 0;
	int           tests_run = 0;
	int           cyc       = 0;
	int           umul [4]  = '{1, UNIT_10MS_N, UNIT_100MS_N, UNIT_1S_N};

	row_t rows [7] = '{
		'{16'h0000, 4'h0, 4'hf, CLASS_VOUT, 2'h0, 3'h0, 3'h0},
		'{16'hf0f0, 4'hf, 4'h0, CLASS_VIN,  2'h1, 3'h0, 3'h0},
		'{16'h50f0, 4'hf, 4'ha, CLASS_IOUT, 2'h2, 3'h0, 3'h0},
		'{16'hf030, 4'h3, 4'hc, CLASS_TEMP, 2'h3, 3'h0, 3'h0},
		'{16'h000f, 4'h0, 4'hf, CLASS_VOUT, 2'h0, 3'h3, 3'h5},
		'{16'h8080, 4'h8, 4'h7, CLASS_IOUT, 2'h0, 3'h7, 3'h0},
		'{16'h1010, 4'h1, 4'he, CLASS_VIN,  2'h0, 3'h1, 3'h6}
	};

	fault_retry_ctrl #(.BASE_CYC(BC)) i_dut
	(
		.I_CORE_CLK         (core_clk),
		.I_RST_B            (rst_b),
		.I_CMD_WR           (wr),
		.I_CMD_RD           (rd),
		.I_CMD_CODE         (code),
		.I_CMD_DATA         (wdata),
		.O_RD_DATA          (rd_data),
		.O_CMD_UNSUP        (unsup),
		.I_FAULT            (fault),
		.I_FAULT_CLASS      (cls),
		.I_CLEAR_FAULT      (clr),
		.I_CLEAR_FAULTS_CMD (clr_cmd),
		.I_CTRL_PIN_ON      (ctrl_on),
		.I_OP_ON            (op_on),
		.I_BIAS_OK          (bias_ok),
		.I_OTHER_SHUTDOWN   (other_sd),
		.O_OUTPUT_EN        (out_en),
		.O_FAULT_LATCHED    (latched),
		.O_SPARE_OUT        (sp_out),
		.O_SPARE_OE_B       (sp_oe_b),
		.O_SPARE_UNUSED     (sp_unused)
	);

	cmd_host_model i_host
	(
		.i_clk     (core_clk),
		.i_rd_data (rd_data),
		.i_unsup   (unsup),
		.o_wr      (wr),
		.o_rd      (rd),
		.o_code    (code),
		.o_data    (wdata)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// a hang counts as a mismatch and still reaches the report
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == TMO)
		begin
			err_count++;
			final_report();
		end
	end

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wr_reg(input logic [7:0] c, input logic [15:0] v);
		i_host.access(1'b1, c, v, rdv, usv);
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] c);
		i_host.access(1'b0, c, 16'h0000, rdv, usv);
	endtask : rd_reg

	// fault held until latch; hold keeps the output on for one full delay
	task automatic run_fault(input row_t w);
		int   d;
		int   n;
		logic early_off;
		d = BC * umul[w.unit] << w.ex;
		n = 0;
		early_off = 1'b0;
		wr_reg(CMD_RESP_UNIT_CFG, {14'h0, w.unit} << (2 * w.c));
		wr_reg(CMD_FAULT_RESP_CFG, {8'h00, 2'h1, w.r, w.ex});
		cls = w.c;
		fault = 1'b1;
		while (latched !== 1'b1 && n < 5000)
		begin
			tick(1);
			n++;
			if (n < d && out_en !== 1'b1)
				early_off = 1'b1;
		end
		chk("latch time", 16'h1, {15'h0, n >= d * (w.r + 1) && n <= (d + 4) * (w.r + 1)});
		chk("on during hold", 16'h0, {15'h0, early_off});
		rd_reg(CMD_RETRY_STATUS);
		chk("latched status", {11'h0, 2'b10, w.r}, rdv);
		fault = 1'b0;
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		tick(3);
		chk("cleared", 16'h2, {14'h0, out_en, latched});
		rd_reg(CMD_RETRY_STATUS);
		chk("fresh status", 16'h0000, rdv);
	endtask : run_fault

	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report

	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial
	begin
		rst_b = 1'b0;
		fault = 1'b0;
		clr = 1'b0;
		clr_cmd = 1'b0;
		ctrl_on = 1'b1;
		op_on = 1'b1;
		bias_ok = 1'b1;
		other_sd = 1'b0;
		cls = CLASS_VOUT;
		tick(16);
		rst_b = 1'b1;
		tick(4);
		chk("oe_b reset", 16'h000f, {12'h0, sp_oe_b});
		chk("unused reset", 16'h0000, {12'h0, sp_unused});
		rd_reg(CMD_SPARE_PIN_USAGE);
		chk("pin cfg reset", RST_SPARE_PIN_USAGE, rdv);
		rd_reg(CMD_RESP_UNIT_CFG);
		chk("unit cfg reset", {8'h00, RST_RESP_UNIT_CFG}, rdv);
		rd_reg(CMD_FAULT_RESP_CFG);
		chk("resp cfg reset", {8'h00, RST_FAULT_RESP_CFG}, rdv);
		rd_reg(8'h00);
		chk("unmapped read", 16'h0001, {rdv[14:0], usv});
		wr_reg(8'h00, 16'hffff);
		chk("unmapped write", 16'h0001, {15'h0, usv});
		$display("test reset done");

		foreach (rows[i])
		begin
			wr_reg(CMD_SPARE_PIN_USAGE, rows[i].pins);
			tick(1);
			chk("unused pins", {12'h0, rows[i].unused}, {12'h0, sp_unused});
			chk("pin oe_b", {12'h0, rows[i].oe_b}, {12'h0, sp_oe_b});
			chk("pin out", 16'h0000, {12'h0, sp_out});
			rd_reg(CMD_SPARE_PIN_USAGE);
			chk("pin cfg read", rows[i].pins, rdv);
			run_fault(rows[i]);
			$display("test row %0d done", i);
		end

		// continuous retry never latches; off by operation command, then by control pin
		wr_reg(CMD_RESP_UNIT_CFG, 16'h0000);
		wr_reg(CMD_FAULT_RESP_CFG, 16'h0078);
		cls = CLASS_VOUT;
		for (int k = 0; k < 2; k++)
		begin
			fault = 1'b1;
			tick(200);
			chk("no latch", 16'h0000, {15'h0, latched});
			rd_reg(CMD_RETRY_STATUS);
			chk("retry state", 16'h0003, {14'h0, rdv[4:3]});
			// control pin passes a two stage synchroniser first
			op_on = (k != 0);
			ctrl_on = (k == 0);
			tick(4);
			rd_reg(CMD_RETRY_STATUS);
			chk("off state", 16'h0000, {13'h0, rdv[4:3], out_en});
			fault = 1'b0;
			op_on = 1'b1;
			ctrl_on = 1'b1;
			tick(4);
			chk("back on", 16'h0001, {15'h0, out_en});
		end
		$display("test continuous done");

		// forced shutdown, then cleared by command and by bias loss
		for (int k = 0; k < 2; k++)
		begin
			other_sd = 1'b1;
			tick(3);
			chk("forced latch", 16'h0001, {14'h0, out_en, latched});
			other_sd = 1'b0;
			clr_cmd = (k == 0);
			bias_ok = (k == 0);
			tick(1);
			clr_cmd = 1'b0;
			tick(2);
			chk("clear latch", 16'h0000, {15'h0, latched});
			bias_ok = 1'b1;
			tick(3);
		end
		$display("test shutdown done");

		// fault gone before the hold ends: output stays on, no latch
		wr_reg(CMD_FAULT_RESP_CFG, 16'h0043);
		fault = 1'b1;
		tick(5);
		chk("on in hold", 16'h0002, {14'h0, out_en, latched});
		fault = 1'b0;
		tick(40);
		rd_reg(CMD_RETRY_STATUS);
		chk("hold recovers", 16'h0002, {14'h0, out_en, latched});
		chk("run after hold", 16'h0000, rdv);
		$display("test hold done");

		// reset in mid-run puts registers and outputs back to reset values
		wr_reg(CMD_SPARE_PIN_USAGE, 16'hf0f0);
		fault = 1'b1;
		tick(3);
		rst_b = 1'b0;
		tick(2);
		chk("in reset", 16'h00f0, {6'h0, out_en, latched, sp_oe_b, sp_unused});
		fault = 1'b0;
		rst_b = 1'b1;
		tick(4);
		chk("after reset", 16'h02f0, {6'h0, out_en, latched, sp_oe_b, sp_unused});
		rd_reg(CMD_SPARE_PIN_USAGE);
		chk("pin cfg mid reset", RST_SPARE_PIN_USAGE, rdv);
		$display("test mid reset done");
		final_report();
	end
endmodule : test_fault_retry_ctrl

// File: hw/fault_retry_ctrl.sv
// fault retry sequencer with spare pin configuration registers
//
// Overview of operation
// - code 101: five restarts, then latch off
// - code 110: six restarts, then latch off
// - code 111: retry until off, bias, shutdown
// - restarts spaced start to start by delay
// - delay field n gives 2**n units
// - same delay for hold and retry spacing
// - unit length from response unit register
// - utilization bit 1 marks pin unused
// - mode bit 1 drives unused pin low
// - bits 15..12: fault2, tms, tdi, tdo
// - unused marking overrides other pin setup
// - per class unit 1ms/10ms/100ms/1s
// - clear by bit, command or off-on cycle
`timescale 1ns/100ps
module fault_retry_ctrl
	import fault_retry_pkg::*;
#(
	parameter int BASE_CYC = BASE_UNIT_CYC
)
(
	// clock and reset
	input  wire logic         I_CORE_CLK,
	input  wire logic         I_RST_B,
	// command port
	input  wire logic         I_CMD_WR,
	input  wire logic         I_CMD_RD,
	input  wire logic [7:0]   I_CMD_CODE,
	input  wire logic [15:0]  I_CMD_DATA,
	output logic [15:0]       O_RD_DATA,
	output logic              O_CMD_UNSUP,
	// fault and run control
	input  wire logic         I_FAULT,
	input  wire fault_class_t I_FAULT_CLASS,
	input  wire logic         I_CLEAR_FAULT,
	input  wire logic         I_CLEAR_FAULTS_CMD,
	input  wire logic         I_CTRL_PIN_ON,
	input  wire logic         I_OP_ON,
	input  wire logic         I_BIAS_OK,
	input  wire logic         I_OTHER_SHUTDOWN,
	// output stage and status
	output logic              O_OUTPUT_EN,
	output logic              O_FAULT_LATCHED,
	// spare pins
	output logic [3:0]        O_SPARE_OUT,
	output logic [3:0]        O_SPARE_OE_B,
	output logic [3:0]        O_SPARE_UNUSED
);

	// ----------------------------------------------------------
	// registers and synchroniser
	// ----------------------------------------------------------
	spare_pin_cfg_t pins_ff;
	logic [7:0]     unit_cfg_ff;
	fault_resp_t    resp_ff;
	logic [15:0]    rd_data_ff;
	logic           unsup_ff;
	logic [1:0]     ctrl_sync_ff;
	retry_state_t   state_ff;
	retry_state_t   nxt_state;
	logic [2:0]     attempts_ff;
	logic [2:0]     nxt_attempts;
	logic           was_on_ff;
	logic           out_en_ff;
	logic           latched_ff;
	logic [3:0]     oe_b_ff;
	logic [3:0]     unused_ff;

	run_ctrl_t run;
	assign run.ctrl_on        = ctrl_sync_ff[1];
	assign run.op_on          = I_OP_ON;
	assign run.bias_ok        = I_BIAS_OK;
	assign run.other_shutdown = I_OTHER_SHUTDOWN;

	wire logic wr_pins  = I_CMD_WR && (I_CMD_CODE == CMD_SPARE_PIN_USAGE);
	wire logic wr_unit  = I_CMD_WR && (I_CMD_CODE == CMD_RESP_UNIT_CFG);
	wire logic wr_resp  = I_CMD_WR && (I_CMD_CODE == CMD_FAULT_RESP_CFG);
	wire logic code_ok  = (I_CMD_CODE == CMD_SPARE_PIN_USAGE) ||
	                      (I_CMD_CODE == CMD_RESP_UNIT_CFG) ||
	                      (I_CMD_CODE == CMD_FAULT_RESP_CFG) ||
	                      (I_CMD_CODE == CMD_RETRY_STATUS);
	wire logic [15:0] rd_mux =
		(I_CMD_CODE == CMD_SPARE_PIN_USAGE) ? pins_ff :
		(I_CMD_CODE == CMD_RESP_UNIT_CFG)   ? {8'h00, unit_cfg_ff} :
		(I_CMD_CODE == CMD_FAULT_RESP_CFG)  ? {8'h00, resp_ff} :
		(I_CMD_CODE == CMD_RETRY_STATUS)    ? {11'h000, state_ff, attempts_ff} : 16'h0000;

	always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			pins_ff      <= RST_SPARE_PIN_USAGE;
			unit_cfg_ff  <= RST_RESP_UNIT_CFG;
			resp_ff      <= RST_FAULT_RESP_CFG;
			rd_data_ff   <= 16'h0000;
			unsup_ff     <= 1'b0;
			ctrl_sync_ff <= 2'h0;
		end
		else
		begin
			if (wr_pins)
				pins_ff <= I_CMD_DATA;
			if (wr_unit)
				unit_cfg_ff <= I_CMD_DATA[7:0];
			if (wr_resp)
				resp_ff <= I_CMD_DATA[7:0];
			rd_data_ff   <= I_CMD_RD ? rd_mux : rd_data_ff;
			unsup_ff     <= (I_CMD_RD || I_CMD_WR) && !code_ok;
			ctrl_sync_ff <= {ctrl_sync_ff[0], I_CTRL_PIN_ON};
		end
	end

	// ----------------------------------------------------------
	// delay timer
	// ----------------------------------------------------------
	// unit from unit register
	wire delay_unit_t cls_unit = delay_unit_t'(unit_cfg_ff[2*I_FAULT_CLASS +: 2]);
	wire logic        cmd_on   = run.ctrl_on && run.op_on;
	wire logic        clear_evt = I_CLEAR_FAULT || I_CLEAR_FAULTS_CMD ||
	                              (cmd_on && !was_on_ff) || !run.bias_ok;
	wire logic        retry_any = resp_ff.retries != RETRY_NONE;
	wire logic        endless   = resp_ff.retries == RETRY_CONTINUOUS;
	wire logic        tries_out = !endless && (attempts_ff >= resp_ff.retries);
	wire logic        timer_done;
	logic             timer_start;

	retry_delay_timer #(
		.BASE_CYC (BASE_CYC)
	) u_timer (
		.i_clk   (I_CORE_CLK),
		.i_rst_b (I_RST_B),
		.i_start (timer_start),
		.i_unit  (cls_unit),
		.i_exp   (resp_ff.delay_exp),
		.o_done  (timer_done)
	);

	// ----------------------------------------------------------
	// retry sequencer
	// ----------------------------------------------------------
	always_comb
	begin
		nxt_state    = state_ff;
		nxt_attempts = attempts_ff;
		timer_start  = 1'b0;
		if (clear_evt || !cmd_on)
		begin
			nxt_state    = ST_RUN;
			nxt_attempts = 3'h0;
			timer_start  = 1'b1;
		end
		else if (run.other_shutdown)
			nxt_state = ST_LATCH;
		else
		begin
			case (state_ff)
				ST_RUN:
					if (I_FAULT)
					begin
						nxt_state   = ST_HOLD;
						timer_start = 1'b1;
					end
				ST_HOLD:
					if (timer_done)
					begin
						if (!I_FAULT)
							nxt_state = ST_RUN;
						else if (retry_any)
						begin
							nxt_state    = ST_RETRY;
							nxt_attempts = 3'h1;
							timer_start  = 1'b1;
						end
						else
							nxt_state = ST_LATCH;
					end
				ST_RETRY:
					if (timer_done)
					begin
						if (!I_FAULT)
							nxt_state = ST_RUN;
						else if (tries_out)
							nxt_state = ST_LATCH;
						else
						begin
							nxt_attempts = endless ? attempts_ff : attempts_ff + 3'h1;
							timer_start  = 1'b1;
						end
					end
				ST_LATCH:
					nxt_state = ST_LATCH;
				default:
					nxt_state = ST_RUN;
			endcase
		end
	end

	// ----------------------------------------------------------
	// spare pins
	// ----------------------------------------------------------
	// unused pin drive
	wire logic [3:0] nxt_oe_b = ~(pins_ff.util & pins_ff.mode);

	always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			state_ff    <= ST_RUN;
			attempts_ff <= 3'h0;
			was_on_ff   <= 1'b0;
			out_en_ff   <= 1'b0;
			latched_ff  <= 1'b0;
			oe_b_ff     <= 4'hf;
			unused_ff   <= 4'h0;
		end
		else
		begin
			state_ff    <= nxt_state;
			attempts_ff <= nxt_attempts;
			was_on_ff   <= cmd_on;
			out_en_ff   <= cmd_on && run.bias_ok &&
			               ((nxt_state == ST_RUN) || (nxt_state == ST_HOLD));
			latched_ff  <= nxt_state == ST_LATCH;
			oe_b_ff     <= nxt_oe_b;
			unused_ff   <= pins_ff.util;
		end
	end

	assign O_RD_DATA       = rd_data_ff;
	assign O_CMD_UNSUP     = unsup_ff;
	assign O_OUTPUT_EN     = out_en_ff;
	assign O_FAULT_LATCHED = latched_ff;
	assign O_SPARE_OUT     = 4'h0;
	assign O_SPARE_OE_B    = oe_b_ff;
	assign O_SPARE_UNUSED  = unused_ff;

	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------
	sequence s_retry_fails;
		(state_ff == ST_RETRY) && timer_done && I_FAULT && cmd_on &&
			!clear_evt && !run.other_shutdown;
	endsequence

	a_five_then_latch: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
		s_retry_fails and (resp_ff.retries == RETRY_FIVE) && (attempts_ff == 3'h5)
			|=> (state_ff == ST_LATCH) && O_FAULT_LATCHED && !O_OUTPUT_EN)
		else $error("code five did not latch after five tries");

	a_six_then_latch: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
		s_retry_fails and (resp_ff.retries == RETRY_SIX) && (attempts_ff == 3'h6)
			|=> (state_ff == ST_LATCH) && O_FAULT_LATCHED && !O_OUTPUT_EN)
		else $error("code six did not latch after six tries");

	a_six_keeps_going: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
		s_retry_fails and (resp_ff.retries == RETRY_SIX) && (attempts_ff == 3'h5)
			|=> (state_ff == ST_RETRY) && (attempts_ff == 3'h6))
		else $error("code six stopped early");

	a_endless_retry: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
		s_retry_fails and (resp_ff.retries == RETRY_CONTINUOUS) |=> state_ff == ST_RETRY)
		else $error("continuous retry stopped");

	a_hold_recovers: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
		(state_ff == ST_HOLD) && timer_done && !I_FAULT && cmd_on && !clear_evt &&
			!run.other_shutdown |=> (state_ff == ST_RUN) && O_OUTPUT_EN)
		else $error("hold did not return to run");

	a_unit_select: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
		cls_unit == {unit_cfg_ff[{I_FAULT_CLASS, 1'b1}], unit_cfg_ff[{I_FAULT_CLASS, 1'b0}]})
		else $error("wrong delay unit for class");

	a_clear_resets: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
		clear_evt |=> (attempts_ff == 3'h0) && (state_ff == ST_RUN) && !O_FAULT_LATCHED)
		else $error("clear did not restart sequence");

	a_used_pin_float: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
		!pins_ff.util[3] |=> O_SPARE_OE_B[3] && !O_SPARE_UNUSED[3])
		else $error("used pin driven by spare logic");

	a_unused_low: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
		pins_ff.util[0] && pins_ff.mode[0] |=> !O_SPARE_OE_B[0] && !O_SPARE_OUT[0])
		else $error("unused output pin not driven low");

endmodule : fault_retry_ctrl

// File: hw/retry_delay_timer.sv
// delay timer: 2**exp units of 1 ms, 10 ms, 100 ms or 1 s
`timescale 1ns/100ps
module retry_delay_timer
	import fault_retry_pkg::*;
#(
	parameter int BASE_CYC = BASE_UNIT_CYC
)
(
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	// control
	input  wire logic        i_start,
	input  wire delay_unit_t i_unit,
	input  wire logic [2:0]  i_exp,
	// result
	output logic             o_done
);

	logic [15:0] base_cnt_ff;
	logic [9:0]  ms_cnt_ff;
	logic [7:0]  unit_cnt_ff;
	logic [7:0]  unit_last_ff;
	delay_unit_t unit_ff;
	logic        busy_ff;
	logic        done_ff;

	function automatic logic [9:0] ms_per_unit(input delay_unit_t u);
		case (u)
			UNIT_10MS:  ms_per_unit = 10'(UNIT_10MS_N - 1);
			UNIT_100MS: ms_per_unit = 10'(UNIT_100MS_N - 1);
			UNIT_1S:    ms_per_unit = 10'(UNIT_1S_N - 1);
			default:    ms_per_unit = 10'h000;
		endcase
	endfunction : ms_per_unit

	wire logic base_tick = busy_ff && (base_cnt_ff == 16'(BASE_CYC - 1));
	wire logic unit_tick = base_tick && (ms_cnt_ff == ms_per_unit(unit_ff));
	wire logic last_unit = unit_tick && (unit_cnt_ff == unit_last_ff);

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			base_cnt_ff  <= 16'h0000;
			ms_cnt_ff    <= 10'h000;
			unit_cnt_ff  <= 8'h00;
			unit_last_ff <= 8'h00;
			unit_ff      <= UNIT_1MS;
			busy_ff      <= 1'b0;
			done_ff      <= 1'b0;
		end
		else if (i_start)
		begin
			base_cnt_ff  <= 16'h0000;
			ms_cnt_ff    <= 10'h000;
			unit_cnt_ff  <= 8'h00;
			unit_last_ff <= 8'((9'h001 << i_exp) - 9'h001);
			unit_ff      <= i_unit;
			busy_ff      <= 1'b1;
			done_ff      <= 1'b0;
		end
		else
		begin
			base_cnt_ff <= base_tick ? 16'h0000 : (busy_ff ? base_cnt_ff + 16'h0001 : base_cnt_ff);
			ms_cnt_ff   <= unit_tick ? 10'h000 : (base_tick ? ms_cnt_ff + 10'h001 : ms_cnt_ff);
			unit_cnt_ff <= unit_tick ? unit_cnt_ff + 8'h01 : unit_cnt_ff;
			busy_ff     <= busy_ff && !last_unit;
			done_ff     <= last_unit;
		end
	end

	assign o_done = done_ff;

	a_done_last_unit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_done |-> $past(unit_cnt_ff) == unit_last_ff)
		else $error("timer done before last unit");

endmodule : retry_delay_timer

// File: include/fault_retry_pkg.sv
// shared constants and types for the fault retry and spare pin block
package fault_retry_pkg;

	// -------------------------------------------------------------
	// command codes
	// -------------------------------------------------------------
	localparam logic [7:0] CMD_SPARE_PIN_USAGE = 8'hc5;
	localparam logic [7:0] CMD_RESP_UNIT_CFG   = 8'hd2;
	localparam logic [7:0] CMD_FAULT_RESP_CFG  = 8'he4;
	localparam logic [7:0] CMD_RETRY_STATUS    = 8'he5;

	// -------------------------------------------------------------
	// reset values
	// -------------------------------------------------------------
	localparam logic [15:0] RST_SPARE_PIN_USAGE = 16'h0000;
	localparam logic [7:0]  RST_RESP_UNIT_CFG   = 8'h00;
	localparam logic [7:0]  RST_FAULT_RESP_CFG  = 8'h00;

	// -------------------------------------------------------------
	// retry codes and counts
	// -------------------------------------------------------------
	localparam logic [2:0] RETRY_NONE       = 3'h0;
	localparam logic [2:0] RETRY_FIVE       = 3'h5;
	localparam logic [2:0] RETRY_SIX        = 3'h6;
	localparam logic [2:0] RETRY_CONTINUOUS = 3'h7;

	// -------------------------------------------------------------
	// timing: core clock and base delay unit
	// -------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 25000;
	localparam int BASE_UNIT_MS  = 1;
	localparam int BASE_UNIT_CYC = (BASE_UNIT_MS * 1000000000) / CLK_PERIOD_PS;
	localparam int UNIT_10MS_N   = 10;
	localparam int UNIT_100MS_N  = 100;
	localparam int UNIT_1S_N     = 1000;

	// -------------------------------------------------------------
	// types
	// -------------------------------------------------------------
	typedef enum logic [1:0]
	{
		UNIT_1MS   = 2'h0,
		UNIT_10MS  = 2'h1,
		UNIT_100MS = 2'h2,
		UNIT_1S    = 2'h3
	} delay_unit_t;

	typedef enum logic [1:0]
	{
		CLASS_VOUT = 2'h0,
		CLASS_VIN  = 2'h1,
		CLASS_IOUT = 2'h2,
		CLASS_TEMP = 2'h3
	} fault_class_t;

	typedef enum logic [1:0]
	{
		ST_RUN   = 2'h0,
		ST_HOLD  = 2'h1,
		ST_RETRY = 2'h3,
		ST_LATCH = 2'h2
	} retry_state_t;

	typedef struct packed
	{
		logic [1:0] action;
		logic [2:0] retries;
		logic [2:0] delay_exp;
	} fault_resp_t;

	// pin order inside each nibble: 3 second fault, 2 tms, 1 tdi, 0 tdo
	typedef struct packed
	{
		logic [3:0] mode;
		logic [3:0] mode_other;
		logic [3:0] util;
		logic [3:0] util_other;
	} spare_pin_cfg_t;

	typedef struct packed
	{
		logic       ctrl_on;
		logic       op_on;
		logic       bias_ok;
		logic       other_shutdown;
	} run_ctrl_t;

endpackage : fault_retry_pkg
